// ===== include/memory_logic_tile_consts.svh
// Offsets, field positions, reset values and sizes of the memory tile
`ifndef MEMORY_LOGIC_TILE_CONSTS_SVH
`define MEMORY_LOGIC_TILE_CONSTS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_ALMOST_FULL 8'h04
`define OFS_ALMOST_EMPTY 8'h08
`define OFS_CAM_MASK_LO 8'h0C
`define OFS_CAM_MASK_HI 8'h10
`define OFS_STATUS 8'h14
// ----------------------------------------------------------------
// Control fields and writable bits
// ----------------------------------------------------------------
`define CTRL_MODE_LSB 0
`define CTRL_WIDTH_LSB 3
`define CTRL_OUT_REG_BIT 6
`define CTRL_SHOW_AHEAD_BIT 7
`define CTRL_MASK_EN_BIT 8
`define CTRL_WRITE_MASK 32'h0000_01FF
`define LEVEL_WRITE_MASK 32'h0000_7FFF
`define MASK_HI_WRITE_MASK 32'h0000_FFFF
`define CTRL_RESET 32'h0000_0000
`define ALMOST_FULL_RESET 32'h0000_3000
`define ALMOST_EMPTY_RESET 32'h0000_0010
`define STATUS_COUNT_LSB 16
// ----------------------------------------------------------------
// Array sizes and bus answers
// ----------------------------------------------------------------
`define ARRAY_BITS 16384
`define ARRAY_ROWS 1024
`define CAM_ENTRIES 128
`define CAM_WIDTH 48
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ===== include/memory_logic_tile_pkg.sv
// Types shared by the memory tile and its users
package memory_logic_tile_pkg;
    typedef enum logic [2:0] {
        mode_true_dual,
        mode_pseudo_dual,
        mode_single,
        mode_fifo,
        mode_cam
    } mode_type;

    typedef struct packed {
        logic cs;
        logic we;
        logic [13:0] addr;
        logic [15:0] wdata;
    } port_req_type;

    typedef struct packed {
        logic match;
        logic multi;
        logic [6:0] addr;
    } cam_result_type;

    typedef struct packed {
        logic full;
        logic empty;
        logic almost_full;
        logic almost_empty;
    } fifo_flags_type;
endpackage : memory_logic_tile_pkg

// ===== rtl/memory_logic_tile.sv
// Multimode memory tile: dual/single-port RAM, FIFO and ternary CAM
// Summary of operation
// - Stored bits have power-on values
// - True dual-port: two ports, 8192 bits
// - Word width 1, 2, 4, 8 or 16
// - Port inputs registered before use, except port A write data in FIFO mode
// - Read data registered or direct
// - Pseudo dual-port: 16384 bits
// - Single-port: one port, 16384 bits
// - FIFO pointers on the one shared clock
// - FIFO data in 16384-bit array
// - Full, empty and almost flags
// - Programmable almost thresholds
// - Read pointer rewind replays frame
// - Optional show-ahead read
// - CAM update writes data at address
// - Match, multi-match, lowest address
// - 128 ternary entries of 48 bits
// - Masked bits kept on update
// - Masked bits skip compare
// - Write don't-care stores wildcards
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "memory_logic_tile_consts.svh"
module memory_logic_tile #(
    parameter logic [`ARRAY_BITS-1:0] init_bits = '0,
    parameter logic [`CAM_ENTRIES*`CAM_WIDTH-1:0] cam_init_data = '0,
    parameter logic [`CAM_ENTRIES*`CAM_WIDTH-1:0] cam_init_care = '1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire memory_logic_tile_pkg::port_req_type port_a,
    input wire memory_logic_tile_pkg::port_req_type port_b,
    output logic [15:0] a_rdata,
    output logic [15:0] b_rdata,
    input wire logic fifo_write,
    input wire logic fifo_read,
    input wire logic fifo_rewind,
    input wire logic fifo_release,
    output memory_logic_tile_pkg::fifo_flags_type fifo_flags,
    input wire logic cam_update,
    input wire logic cam_write_dont_care,
    input wire logic [6:0] cam_addr,
    input wire logic [47:0] cam_wdata,
    input wire logic cam_compare,
    input wire logic [47:0] cam_key,
    output memory_logic_tile_pkg::cam_result_type cam_result
);
    // ----------------------------------------------------------------
    // Element addressing helpers
    // ----------------------------------------------------------------
    function automatic logic [9:0] row_of(input logic [13:0] e, input logic [2:0] k);
        row_of = 10'(e >> (3'd4 - k));
    endfunction : row_of
    function automatic logic [3:0] off_of(input logic [13:0] e, input logic [2:0] k);
        off_of = 4'((e[3:0] & (4'hF >> k)) << k);
    endfunction : off_of
    function automatic logic [15:0] lane_mask(input logic [13:0] e, input logic [2:0] k);
        lane_mask = 16'(((17'd1 << (5'd1 << k)) - 17'd1) << off_of(e, k));
    endfunction : lane_mask
    function automatic logic [15:0] extract(input logic [15:0] row, input logic [13:0] e,
                                            input logic [2:0] k);
        extract = (row & lane_mask(e, k)) >> off_of(e, k);
    endfunction : extract
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb, input logic [31:0] wmask);
        logic [31:0] bytes;
        bytes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
        merge = (old & ~bytes) | (data & bytes);
    endfunction : merge
    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    logic [31:0] ctrl_reg, af_reg, ae_reg, mask_lo, mask_hi;
    memory_logic_tile_pkg::mode_type mode;
    logic [2:0] k;
    logic out_reg, show_ahead, mask_en;
    logic [47:0] cam_mask;
    logic [13:0] addr_mask;
    logic [14:0] depth;
    always_comb begin
        mode = memory_logic_tile_pkg::mode_type'(ctrl_reg[`CTRL_MODE_LSB +: 3]);
        k = (ctrl_reg[`CTRL_WIDTH_LSB +: 3] > 3'd4) ? 3'd4 : ctrl_reg[`CTRL_WIDTH_LSB +: 3];
        out_reg = ctrl_reg[`CTRL_OUT_REG_BIT];
        show_ahead = ctrl_reg[`CTRL_SHOW_AHEAD_BIT];
        mask_en = ctrl_reg[`CTRL_MASK_EN_BIT];
        cam_mask = {mask_hi[15:0], mask_lo};
        depth = 15'(15'h4000 >> k);
        addr_mask = (mode == memory_logic_tile_pkg::mode_true_dual)
            ? 14'(14'h3FFF >> (k + 3'd1)) : 14'(14'h3FFF >> k);
    end
    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    logic aw_hold, w_hold, do_write, next_aw_hold, next_w_hold, next_bvalid, next_rvalid;
    logic [7:0] aw_addr;
    logic [3:0] w_strb;
    logic [31:0] w_data, status_word;
    logic [14:0] fifo_count;
    always_comb begin
        do_write = aw_hold & w_hold & ~s_axi_bvalid;
        next_aw_hold = do_write ? 1'b0 : (aw_hold | (s_axi_awvalid & s_axi_awready));
        next_w_hold = do_write ? 1'b0 : (w_hold | (s_axi_wvalid & s_axi_wready));
        next_bvalid = s_axi_bvalid ? ~s_axi_bready : do_write;
        next_rvalid = s_axi_rvalid ? ~s_axi_rready : (s_axi_arvalid & s_axi_arready);
        status_word = '0;
        status_word[5:0] = {cam_result.multi, cam_result.match, fifo_flags.almost_empty,
                            fifo_flags.almost_full, fifo_flags.empty, fifo_flags.full};
        status_word[`STATUS_COUNT_LSB +: 15] = fifo_count;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            aw_hold <= next_aw_hold;
            w_hold <= next_w_hold;
            s_axi_awready <= ~next_aw_hold & ~next_bvalid;
            s_axi_wready <= ~next_w_hold & ~next_bvalid;
            s_axi_bvalid <= next_bvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bresp <= (aw_addr[7:2] > 6'd5 || aw_addr[1:0] != 2'd0)
                    ? `RESP_SLVERR : `RESP_OKAY;
            end
        end
    end
    // Status is read-only; writes to it are ignored
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= `CTRL_RESET;
            af_reg <= `ALMOST_FULL_RESET;
            ae_reg <= `ALMOST_EMPTY_RESET;
            mask_lo <= 32'h0000_0000;
            mask_hi <= 32'h0000_0000;
        end else if (do_write) begin
            if (aw_addr == `OFS_CTRL) begin
                ctrl_reg <= merge(ctrl_reg, w_data, w_strb, `CTRL_WRITE_MASK);
            end else if (aw_addr == `OFS_ALMOST_FULL) begin
                af_reg <= merge(af_reg, w_data, w_strb, `LEVEL_WRITE_MASK);
            end else if (aw_addr == `OFS_ALMOST_EMPTY) begin
                ae_reg <= merge(ae_reg, w_data, w_strb, `LEVEL_WRITE_MASK);
            end else if (aw_addr == `OFS_CAM_MASK_LO) begin
                mask_lo <= merge(mask_lo, w_data, w_strb, 32'hFFFF_FFFF);
            end else if (aw_addr == `OFS_CAM_MASK_HI) begin
                mask_hi <= merge(mask_hi, w_data, w_strb, `MASK_HI_WRITE_MASK);
            end
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            s_axi_arready <= ~next_rvalid;
            s_axi_rvalid <= next_rvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rresp <= `RESP_OKAY;
                if (s_axi_araddr == `OFS_CTRL) begin
                    s_axi_rdata <= ctrl_reg;
                end else if (s_axi_araddr == `OFS_ALMOST_FULL) begin
                    s_axi_rdata <= af_reg;
                end else if (s_axi_araddr == `OFS_ALMOST_EMPTY) begin
                    s_axi_rdata <= ae_reg;
                end else if (s_axi_araddr == `OFS_CAM_MASK_LO) begin
                    s_axi_rdata <= mask_lo;
                end else if (s_axi_araddr == `OFS_CAM_MASK_HI) begin
                    s_axi_rdata <= mask_hi;
                end else if (s_axi_araddr == `OFS_STATUS) begin
                    s_axi_rdata <= status_word;
                end else begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `RESP_SLVERR;
                end
            end
        end
    end
    // ----------------------------------------------------------------
    // RAM ports and storage array
    // ----------------------------------------------------------------
    logic [15:0] mem [0:`ARRAY_ROWS-1];
    memory_logic_tile_pkg::port_req_type a_q, b_q;
    logic [15:0] a_stage, b_stage;
    // Power-on contents only, so the array can act as ROM
    initial begin
        for (int i = 0; i < `ARRAY_ROWS; i++) begin
            mem[i] = init_bits[i*16 +: 16];
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            a_q <= '0;
            b_q <= '0;
        end else begin
            a_q <= port_a;
            b_q <= port_b;
        end
    end
    logic [13:0] ea, eb, ew, er, wa_e;
    logic [14:0] wptr, rptr, base, used, next_rptr;
    logic wr_ok, rd_ok, wa, wb;
    logic [15:0] da, db, ma, mb;
    always_comb begin
        ea = a_q.addr & addr_mask;
        eb = b_q.addr & addr_mask;
        ew = wptr[13:0] & addr_mask;
        er = next_rptr[13:0] & addr_mask;
        wa_e = (mode == memory_logic_tile_pkg::mode_fifo) ? ew : ea;
        wa = 1'b0;
        wb = 1'b0;
        case (mode)
            memory_logic_tile_pkg::mode_true_dual: begin
                wa = a_q.cs & a_q.we;
                wb = b_q.cs & b_q.we;
            end
            memory_logic_tile_pkg::mode_pseudo_dual, memory_logic_tile_pkg::mode_single: begin
                wa = a_q.cs & a_q.we;
            end
            memory_logic_tile_pkg::mode_fifo: begin
                wa = wr_ok;
            end
            default: begin
                wa = 1'b0;
            end
        endcase
        ma = lane_mask(wa_e, k);
        mb = lane_mask(eb, k);
        da = 16'(((mode == memory_logic_tile_pkg::mode_fifo) ? port_a.wdata : a_q.wdata)
            << off_of(wa_e, k)) & ma;
        db = 16'(b_q.wdata << off_of(eb, k)) & mb;
    end
    // One process so shared-row lanes merge; port B wins a clash
    always @(posedge clk) begin
        if (wa && wb && row_of(wa_e, k) == row_of(eb, k)) begin
            mem[row_of(eb, k)] <= (mem[row_of(eb, k)] & ~(ma | mb)) | (da & ~mb) | db;
        end else begin
            if (wa) begin
                mem[row_of(wa_e, k)] <= (mem[row_of(wa_e, k)] & ~ma) | da;
            end
            if (wb) begin
                mem[row_of(eb, k)] <= (mem[row_of(eb, k)] & ~mb) | db;
            end
        end
    end
    // Direct mode answers a cycle sooner; registered mode eases timing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            a_stage <= 16'h0000;
            b_stage <= 16'h0000;
            a_rdata <= 16'h0000;
            b_rdata <= 16'h0000;
        end else begin
            a_stage <= extract(mem[row_of(ea, k)], ea, k);
            b_stage <= extract(mem[row_of(eb, k)], eb, k);
            a_rdata <= out_reg ? a_stage : extract(mem[row_of(ea, k)], ea, k);
            if (mode == memory_logic_tile_pkg::mode_fifo) begin
                if (show_ahead || rd_ok) begin
                    b_rdata <= extract(mem[row_of(er, k)], er, k);
                end
            end else begin
                b_rdata <= out_reg ? b_stage : extract(mem[row_of(eb, k)], eb, k);
            end
        end
    end
    // ----------------------------------------------------------------
    // FIFO pointer control
    // ----------------------------------------------------------------
    // Read entries kept until released, for rewind
    always_comb begin
        fifo_count = wptr - rptr;
        used = wptr - base;
        wr_ok = (mode == memory_logic_tile_pkg::mode_fifo) && fifo_write
            && used != depth;
        rd_ok = (mode == memory_logic_tile_pkg::mode_fifo) && fifo_read
            && fifo_count != 15'd0 && !fifo_rewind;
        if (fifo_rewind) begin
            next_rptr = base;
        end else if (rd_ok && show_ahead) begin
            next_rptr = rptr + 15'd1;
        end else begin
            next_rptr = rptr;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wptr <= 15'd0;
            rptr <= 15'd0;
            base <= 15'd0;
        end else if (mode == memory_logic_tile_pkg::mode_fifo) begin
            if (wr_ok) begin
                wptr <= wptr + 15'd1;
            end
            if (fifo_rewind) begin
                rptr <= base;
            end else if (rd_ok) begin
                rptr <= rptr + 15'd1;
            end
            if (fifo_release && !fifo_rewind) begin
                base <= rptr;
            end
        end
    end
    logic [14:0] next_count;
    assign next_count = wptr + 15'(wr_ok) - (fifo_rewind ? base : (rptr + 15'(rd_ok)));
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fifo_flags <= '{full: 1'b0, empty: 1'b1, almost_full: 1'b0, almost_empty: 1'b1};
        end else begin
            fifo_flags.full <= (wptr + 15'(wr_ok) - ((fifo_release && !fifo_rewind)
                ? rptr : base)) == depth;
            fifo_flags.empty <= next_count == 15'd0;
            fifo_flags.almost_full <= next_count >= af_reg[14:0];
            fifo_flags.almost_empty <= next_count <= ae_reg[14:0];
        end
    end
    // ----------------------------------------------------------------
    // Ternary CAM
    // ----------------------------------------------------------------
    // Care bit 0 matches any key bit
    logic [47:0] cam_data [0:`CAM_ENTRIES-1], cam_care [0:`CAM_ENTRIES-1];
    logic [`CAM_ENTRIES-1:0] hit;
    logic [47:0] keep_bits;
    logic [6:0] first_hit;
    logic hit_any, hit_multi;
    initial begin
        for (int i = 0; i < `CAM_ENTRIES; i++) begin
            cam_data[i] = cam_init_data[i*48 +: 48];
            cam_care[i] = cam_init_care[i*48 +: 48];
        end
    end
    assign keep_bits = mask_en ? cam_mask : 48'h0000_0000_0000;
    always @(posedge clk) begin
        if (mode == memory_logic_tile_pkg::mode_cam && cam_update) begin
            cam_data[cam_addr] <= (cam_data[cam_addr] & keep_bits)
                | (cam_wdata & ~keep_bits);
            cam_care[cam_addr] <= (cam_care[cam_addr] & keep_bits)
                | ({48{~cam_write_dont_care}} & ~keep_bits);
        end
    end
    // Full parallel compare; a deep cone traded for single-cycle lookup
    generate
        for (genvar i = 0; i < `CAM_ENTRIES; i++) begin : g_compare
            assign hit[i] = ((cam_data[i] ^ cam_key) & cam_care[i] & ~keep_bits)
                == 48'h0000_0000_0000;
        end
    endgenerate
    always_comb begin
        first_hit = 7'd0;
        for (int i = `CAM_ENTRIES - 1; i >= 0; i--) begin
            if (hit[i]) begin
                first_hit = 7'(i);
            end
        end
        hit_any = |hit;
        hit_multi = (hit & (hit - `CAM_ENTRIES'(1))) != '0;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cam_result <= '0;
        end else if (mode == memory_logic_tile_pkg::mode_cam && cam_compare) begin
            cam_result.match <= hit_any;
            cam_result.multi <= hit_multi;
            cam_result.addr <= first_hit;
        end
    end
endmodule : memory_logic_tile

// ===== dv/memory_logic_tile_checker.sv
// Port assertions for the memory tile
`timescale 1ns/1ps
module tile_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic fifo_write,
    input wire logic fifo_read,
    input wire logic fifo_rewind,
    input wire logic fifo_release,
    input wire memory_logic_tile_pkg::fifo_flags_type fifo_flags,
    input wire logic cam_compare,
    input wire memory_logic_tile_pkg::cam_result_type cam_result
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // ----
    // Bus timing, FIFO refusals, CAM result
    // ----
    sequence both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence resp_late;
        ##2 s_axi_bvalid;
    endsequence
    chk_write_resp: assert property (both_taken |-> resp_late)
        else $error("bvalid late");
    chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read answer late");
    // Release may free space, so it is excluded
    chk_full_refuse: assert property (fifo_flags.full && fifo_write && !fifo_read
        && !fifo_release |=> fifo_flags.full) else $error("write accepted when full");
    chk_empty_refuse: assert property (fifo_flags.empty && fifo_read && !fifo_write
        && !fifo_rewind |=> fifo_flags.empty) else $error("read accepted when empty");
    chk_almost_empty: assert property (fifo_flags.empty |->
        fifo_flags.almost_empty) else $error("almost empty low while empty");
    chk_cam_hold: assert property (!cam_compare |=> $stable(cam_result))
        else $error("cam result moved");
    chk_multi_match: assert property (cam_result.multi |-> cam_result.match)
        else $error("multiple match without match");
endmodule : tile_checker
bind memory_logic_tile tile_checker chk_inst (.*);

// ===== dv/fifo_source.sv
// Far-side user logic streaming counting words into the FIFO
`timescale 1ns/1ps
module fifo_source (
    input wire logic clk,
    input wire logic rst,
    input wire logic go,
    output logic push,
    output logic [15:0] data
);
    logic [15:0] count;
    // ----
    // One word per clock while go is high
    // ----
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            push <= 1'b0;
        end else begin
            push <= go;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= 16'h0000;
        end else if (push) begin
            count <= count + 16'h0001;
        end
    end
    // Idle data scrambled to expose stray samples
    assign data = push ? count : ~count;
endmodule : fifo_source

// ===== dv/multimode_memory_block_test.sv
// Self-checking bench for the memory tile
`timescale 1ns/1ps
module multimode_memory_block_test;
    logic clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, look;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    memory_logic_tile_pkg::port_req_type pa, port_b, pa_mux;
    logic [15:0] a_rdata, b_rdata, src_data, lfsr_state;
    logic fifo_on, go, push, fifo_read, fifo_rewind, fifo_release;
    logic cam_update, cam_compare, cam_write_dont_care;
    memory_logic_tile_pkg::fifo_flags_type fifo_flags;
    memory_logic_tile_pkg::cam_result_type cam_result;
    logic [6:0] cam_addr;
    logic [47:0] cam_wdata, cam_key, key;
    logic [47:0] exp_q[$];
    logic [2:0] sel;
    int n_mismatch, num_checks, cycles;
    // ----
    // Design, far-side writer, checks
    // ----
    assign s_axi_wstrb = 4'hF;
    assign pa_mux = fifo_on ? {pa[31:16], src_data} : pa;
    fifo_source src (.clk(clk), .rst(rst), .go(go), .push(push), .data(src_data));
    memory_logic_tile dut (.port_a(pa_mux), .fifo_write(push), .*);
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic compare(input string nm, input logic [47:0] got);
        logic [47:0] want;
        want = exp_q.pop_front();
        num_checks++;
        if (got !== want) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, want, got);
        end
    endtask : compare
    always @(posedge clk) begin
        if (s_axi_rvalid && s_axi_rready) compare("rdata", {14'h0000, s_axi_rresp, s_axi_rdata});
    end
    always @(negedge clk) begin
        if (look) begin
            case (sel)
                3'h1: compare("a_rdata", {32'h0000_0000, a_rdata});
                3'h2: compare("b_rdata", {32'h0000_0000, b_rdata});
                3'h3: compare("fifo_flags", {44'h000_0000_0000, fifo_flags});
                default: compare("cam_result", {39'h00_0000_0000, cam_result});
            endcase
        end
    end
    task automatic chk(input logic [2:0] s, input logic [15:0] e);
        exp_q.push_back({32'h0000_0000, e});
        sel <= s;
        look <= 1'b1;
        @(posedge clk);
        look <= 1'b0;
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) s_axi_bready <= 1'b0;
        end while (s_axi_bready);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        exp_q.push_back({14'h0000, e});
        @(posedge clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) s_axi_rready <= 1'b0;
        end while (s_axi_rready);
    endtask : rd
    task automatic rdf(input logic [15:0] v);
        @(posedge clk);
        fifo_read <= 1'b1;
        @(posedge clk);
        fifo_read <= 1'b0;
        chk(3'h2, v);
    endtask : rdf
    task automatic cam(input logic u, input logic dc, input logic [6:0] a, input logic [47:0] d);
        @(posedge clk);
        {cam_update, cam_compare, cam_write_dont_care} <= {u, ~u, dc};
        cam_addr <= a;
        cam_wdata <= d;
        cam_key <= d;
        @(posedge clk);
        {cam_update, cam_compare} <= 2'h0;
    endtask : cam
    task automatic look_up(input logic [47:0] d, input logic [15:0] e);
        cam(1'b0, 1'b0, 7'h00, d);
        chk(3'h4, e);
    endtask : look_up
    task automatic give_verdict();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        {rst, n_mismatch, num_checks, cycles, lfsr_state} = {1'b1, 96'h0, 16'hDA11};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {go, fifo_on, fifo_read, fifo_rewind, fifo_release, look, sel} = '0;
        {cam_update, cam_compare, cam_write_dont_care, cam_addr, cam_wdata, cam_key} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, pa, port_b} = '0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        rd(8'h00, 34'h0_0000_0000);
        rd(8'h08, 34'h0_0000_0010);
        rd(8'h18, 34'h2_0000_0000);
        wr(8'h04, 32'h0000_0400);
        rd(8'h04, 34'h0_0000_0400);
        // Direct then registered read data, port A writes, both ports read
        for (int m = 0; m < 2; m++) begin
            wr(8'h00, m ? 32'h0000_0060 : 32'h0000_0020);
            for (int i = 1; i < 4; i++) begin
                lfsr_state = lfsr(lfsr_state);
                @(posedge clk);
                pa <= {2'h3, 14'(i * 97 + m), lfsr_state};
                port_b <= {2'h0, 14'(i * 97 + m), 16'h0000};
                @(posedge clk);
                pa.we <= 1'b0;
                repeat (3) @(posedge clk);
                chk(3'h1, lfsr_state);
                chk(3'h2, lfsr_state);
            end
        end
        wr(8'h00, 32'h0000_0023);
        fifo_on <= 1'b1;
        chk(3'h3, 16'h0005);
        go <= 1'b1;
        repeat (1030) @(posedge clk);
        go <= 1'b0;
        repeat (2) @(posedge clk);
        chk(3'h3, 16'h000A);
        rdf(16'h0000);
        rdf(16'h0001);
        @(posedge clk);
        fifo_rewind <= 1'b1;
        @(posedge clk);
        fifo_rewind <= 1'b0;
        for (int i = 0; i < 1024; i++) rdf(i[15:0]);
        @(posedge clk);
        fifo_release <= 1'b1;
        @(posedge clk);
        {fifo_release, fifo_on} <= 2'h0;
        chk(3'h3, 16'h0005);
        wr(8'h00, 32'h0000_0004);
        key = {lfsr_state, 16'h5A5A, ~lfsr_state};
        cam(1'b1, 1'b0, 7'h05, key);
        look_up(key, 16'h0105);
        cam(1'b1, 1'b0, 7'h02, key);
        look_up(key, 16'h0182);
        wr(8'h0C, 32'h0000_00FF);
        wr(8'h00, 32'h0000_0104);
        look_up(key ^ 48'h0000_0000_00FF, 16'h0182);
        cam(1'b1, 1'b0, 7'h05, 48'h0000_0000_0000);
        look_up(key ^ 48'h0000_0000_00FF, 16'h0102);
        cam(1'b1, 1'b1, 7'h09, 48'h0000_0000_0000);
        look_up(~key, 16'h0109);
        give_verdict();
    end
endmodule : multimode_memory_block_test
